// file: hdl/fhb_bus_iface.sv
// Host bus side of the floppy interface: decode, data path, link sequencing, arbitration
// Summary of operation
// - Access recognised when A17..A13 ones, A12..A3 match jumpers, and master sync.
// - Address bit 1 picks data buffer, else control/status; never both.
// - Bus C1 high means write into device, low means read.
// - Data buffer read drives all eight shift register bits on D7..D0.
// - Control/status read drives D7..D4 of the low byte, plus D15 while controller error is set.
// - Writes disable all drivers and take D7..D0.
// - Status read returns done, interrupt enable, transfer request via mux.
// - Controller error asserts D15 on status reads.
// - Shift register parallel loads bus data when not busy and load asserted.
// - Busy plus shift pulse moves register toward last stage, out to controller.
// - Busy, no load: shift pulses bring controller serial data in.
// - Any data buffer access sets run, unless busy or initialize is asserted in that cycle.
// - Run with done passes a command; run without done moves data.
// - Run clears on interface initialize or link busy.
// - Busy exactly when transfer request and done both negated.
// - Controller-to-host: request means element ready; run fetches next.
// - Host-to-controller: request means controller ready; run says element available.
// - Sent elements carry eight data bits then one parity bit.
// - Done and enable, not yet serviced since either last dropped, raise bus request.
// - Grant sets select-ack; grant, busy, sync idle then take bus mastership.
// - As master, assert interrupt and drive jumper vector on D8..D2.
`timescale 1ns/100ps
module fhb_bus_iface
   import fhb_pkg::*;
#(
   parameter logic [JMP_W-1:0] ADDR_JUMPERS = ADDR_JMP_DEF,
   parameter logic [8:0] VECTOR_JUMPERS = VECTOR_DEF,
   parameter logic ODD_PARITY = 1'b1
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [fhb_pkg::ADDR_W-1:0] bus_addr_in,
   input wire logic bus_msyn_in,
   input wire logic bus_c1_in,
   input wire logic bus_init_in,
   input wire logic [fhb_pkg::DATA_W-1:0] bus_data_in,
   output logic [fhb_pkg::DATA_W-1:0] bus_data_out,
   output logic [fhb_pkg::DATA_W-1:0] bus_data_oe_out,
   output logic bus_ssyn_out,
   input wire logic bus_ssyn_in,
   output logic bus_request_out,
   input wire logic grant_input_in,
   input wire logic bus_bbsy_in,
   output logic bus_bbsy_out,
   output logic bus_intr_out,
   input wire logic xfer_request_in,
   input wire logic link_done_in,
   input wire logic link_out_dir_in,
   input wire logic link_error_in,
   input wire logic serial_shift_pulse_in,
   input wire logic serial_in_bit_in,
   output logic serial_out_bit_out,
   output logic link_run_out,
   output logic interface_initialize_out
);
   import fhb_pkg::*;

   localparam int BUS_SW = ADDR_W + DATA_W + 6;

   typedef struct packed {
      logic sel_db_d;
      logic sel_cs_d;
      logic shift_d;
      logic run;
      logic int_enb;
      logic taken;
      logic init_out;
      logic ssyn;
      fhb_arb_t arb;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] doe;
   } fhb_state_t;

   fhb_state_t st_reg;
   fhb_state_t st_next;

   logic [BUS_SW-1:0] bus_s;
   logic [5:0] link_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] wdata_s;
   logic msyn_s;
   logic c1_s;
   logic init_s;
   logic bg_s;
   logic bbsy_s;
   logic ssyn_s;
   logic xreq_s;
   logic done_s;
   logic dir_s;
   logic err_s;
   logic shift_s;
   logic ser_s;
   logic reg_select;
   logic sel_db;
   logic sel_cs;
   logic busy;
   logic write_dir;
   logic read_dir;
   logic shift_pulse;
   logic parallel_load_ctl;
   logic [7:0] sreg;
   logic [7:0] status_byte;

   fhb_sync #(.WIDTH(BUS_SW)) u_bus_sync (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .async_in({bus_addr_in, bus_data_in, bus_msyn_in, bus_c1_in, bus_init_in,
                 grant_input_in, bus_bbsy_in, bus_ssyn_in}),
      .sync_out(bus_s)
   );

   fhb_sync #(.WIDTH(6)) u_link_sync (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .async_in({xfer_request_in, link_done_in, link_out_dir_in, link_error_in,
                 serial_shift_pulse_in, serial_in_bit_in}),
      .sync_out(link_s)
   );

   assign {addr_s, wdata_s, msyn_s, c1_s, init_s, bg_s, bbsy_s, ssyn_s} = bus_s;
   assign {xreq_s, done_s, dir_s, err_s, shift_s, ser_s} = link_s;

   // Address decode against jumper field
   assign reg_select = msyn_s && (addr_s[ADDR_W-1:ADDR_TOP_LSB] == ADDR_TOP_ONES)
                       && (addr_s[ADDR_TOP_LSB-1:ADDR_JMP_LSB] == ADDR_JUMPERS);
   assign sel_db = reg_select && addr_s[ADDR_REG_BIT];
   assign sel_cs = reg_select && !addr_s[ADDR_REG_BIT];
   assign write_dir = c1_s;
   assign read_dir = !c1_s;

   // Busy also gates serial shifting in the shift register
   assign busy = !xreq_s && !done_s;
   assign shift_pulse = shift_s && !st_reg.shift_d;
   assign parallel_load_ctl = write_dir && (sel_db || sel_cs) && !st_reg.sel_db_d
                              && !st_reg.sel_cs_d;

   // Direction line is the controller's business; shift handles both ways
   fhb_shift #(.ODD_PARITY(ODD_PARITY)) u_shift (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .load_in(parallel_load_ctl),
      .load_data_in(wdata_s[7:0]),
      .shift_in(shift_pulse),
      .serial_in_bit_in(ser_s),
      .busy_in(busy),
      .sreg_out(sreg),
      .serial_out(serial_out_bit_out)
   );

   // Status byte in the low data path, bits below 4 unused
   always_comb begin
      status_byte = 8'h00;
      status_byte[CSR_DONE_BIT] = done_s;
      status_byte[CSR_IE_BIT] = st_reg.int_enb;
      status_byte[CSR_XREQ_BIT] = xreq_s;
   end

   always_comb begin
      st_next = st_reg;
      st_next.sel_db_d = sel_db;
      st_next.sel_cs_d = sel_cs;
      st_next.shift_d = shift_s;
      st_next.ssyn = sel_db || sel_cs;
      st_next.init_out = init_s;
      st_next.dout = '0;
      st_next.doe = '0;

      // Mux between buffer data and status, read direction only
      if (sel_db && read_dir) begin
         st_next.dout[7:0] = sreg;
         st_next.doe[7:0] = 8'hff;
      end else if (sel_cs && read_dir) begin
         st_next.dout[7:CSR_STAT_LSB] = status_byte[7:CSR_STAT_LSB];
         st_next.doe[7:CSR_STAT_LSB] = 4'hf;
         st_next.dout[CSR_ERR_BIT] = err_s;
         st_next.doe[CSR_ERR_BIT] = err_s;
      end

      if (sel_cs && write_dir && !st_reg.sel_cs_d) begin
         st_next.int_enb = wdata_s[CSR_IE_BIT];
      end

      // Run carries a command when done, data otherwise; controller tells which
      if (sel_db && !st_reg.sel_db_d) begin
         st_next.run = 1'b1;
      end
      if (init_s || busy) begin
         st_next.run = 1'b0;
      end

      // Once serviced, wait for done or enable to drop before asking again
      if (!done_s || !st_reg.int_enb) begin
         st_next.taken = 1'b0;
      end

      case (st_reg.arb)
         FHB_ARB_IDLE: begin
            if (done_s && st_reg.int_enb && !st_reg.taken) begin
               st_next.arb = FHB_ARB_REQ;
            end
         end
         FHB_ARB_REQ: begin
            if (!(done_s && st_reg.int_enb)) begin
               st_next.arb = FHB_ARB_IDLE;
            end else if (bg_s) begin
               st_next.arb = FHB_ARB_SACK;
            end
         end
         FHB_ARB_SACK: begin
            if (!bg_s && !bbsy_s && !ssyn_s) begin
               st_next.arb = FHB_ARB_MASTER;
            end
         end
         FHB_ARB_MASTER: begin
            if (ssyn_s) begin
               st_next.arb = FHB_ARB_IDLE;
               st_next.taken = 1'b1;
            end
         end
         default: begin
            st_next.arb = FHB_ARB_IDLE;
         end
      endcase

      if (st_next.arb == FHB_ARB_MASTER) begin
         st_next.dout[8:VEC_LSB] = VECTOR_JUMPERS[8:VEC_LSB];
         st_next.doe[8:VEC_LSB] = {VEC_W{1'b1}};
      end

      if (init_s) begin
         st_next.int_enb = CSR_IE_RST;
         st_next.arb = FHB_ARB_IDLE;
         st_next.taken = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_reg <= '{sel_db_d: 1'b0, sel_cs_d: 1'b0, shift_d: 1'b0, run: RUN_RST,
                     int_enb: CSR_IE_RST, taken: 1'b0, init_out: 1'b0, ssyn: 1'b0,
                     arb: FHB_ARB_IDLE, dout: '0, doe: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus_data_out = st_reg.dout;
   assign bus_data_oe_out = st_reg.doe;
   assign bus_ssyn_out = st_reg.ssyn;
   assign bus_request_out = (st_reg.arb == FHB_ARB_REQ);
   assign bus_bbsy_out = (st_reg.arb == FHB_ARB_MASTER);
   assign bus_intr_out = (st_reg.arb == FHB_ARB_MASTER);
   assign link_run_out = st_reg.run;
   assign interface_initialize_out = st_reg.init_out;

   a_sel_exclusive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !(sel_db && sel_cs))
      else $error("both registers selected at once");

   a_db_read_drive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (sel_db && read_dir) |=> (bus_data_oe_out[7:0] == 8'hff)
         && (bus_data_out[7:0] == $past(sreg)))
      else $error("buffer read did not drive shift register byte");

   a_cs_read_lines: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (sel_cs && read_dir && !init_s) |=> (bus_data_oe_out[7:4] == 4'hf)
         && (bus_data_oe_out[3:0] == 4'h0))
      else $error("status read drove wrong data lines");

   a_write_no_drive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (reg_select && write_dir) |=> (bus_data_oe_out[7:0] == 8'h00))
      else $error("drivers enabled during write");

   a_error_d15: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (sel_cs && read_dir && err_s) |=> bus_data_oe_out[CSR_ERR_BIT]
         && bus_data_out[CSR_ERR_BIT])
      else $error("error not shown on D15");

   a_run_set_db: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (sel_db && !st_reg.sel_db_d && !busy && !init_s) |=> link_run_out)
      else $error("buffer access did not set run");

   a_run_clear: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (busy || init_s) |=> !link_run_out)
      else $error("run not cleared by busy or initialize");

   a_req_gate: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(bus_request_out) |-> $past(done_s) && $past(st_reg.int_enb) && !bus_bbsy_out)
      else $error("bus request without done and enable");

   a_master_entry: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(bus_bbsy_out) |-> !$past(bg_s) && !$past(bbsy_s) && !$past(ssyn_s))
      else $error("took mastership with bus lines not idle");

   a_master_vector: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      bus_bbsy_out |-> bus_intr_out && (bus_data_out[8:2] == VECTOR_JUMPERS[8:2])
         && (bus_data_oe_out[8:2] == 7'h7f))
      else $error("vector or interrupt missing while master");
endmodule

// file: hdl/fhb_pkg.sv
// Constants and state encodings for the floppy host bus interface
package fhb_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int JMP_W = 10;
   localparam int VEC_W = 7;
   localparam logic [4:0] ADDR_TOP_ONES = 5'h1f;
   localparam int ADDR_TOP_LSB = 13;
   localparam int ADDR_JMP_LSB = 3;
   localparam int ADDR_REG_BIT = 1;
   localparam int VEC_LSB = 2;
   localparam int CSR_STAT_LSB = 4;
   localparam int CSR_DONE_BIT = 5;
   localparam int CSR_IE_BIT = 6;
   localparam int CSR_XREQ_BIT = 7;
   localparam int CSR_ERR_BIT = 15;
   localparam logic CSR_IE_RST = 1'b0;
   localparam logic RUN_RST = 1'b0;
   localparam int SER_BITS = 8;
   localparam logic [3:0] SER_CNT_RST = 4'h0;
   localparam logic [7:0] SREG_RST = 8'h00;
   // Default jumper address bits 12:3 and interrupt vector (octal 264)
   localparam logic [JMP_W-1:0] ADDR_JMP_DEF = 10'h3cf;
   localparam logic [8:0] VECTOR_DEF = 9'h0b4;
   typedef enum logic [3:0] {
      FHB_ARB_IDLE = 4'b0001,
      FHB_ARB_REQ = 4'b0010,
      FHB_ARB_SACK = 4'b0100,
      FHB_ARB_MASTER = 4'b1000
   } fhb_arb_t;
endpackage

// file: hdl/fhb_shift.sv
// Eight-bit interface shift register with bit counter and parity append
`timescale 1ns/100ps
module fhb_shift
   import fhb_pkg::*;
#(
   parameter logic ODD_PARITY = 1'b1
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic [7:0] load_data_in,
   input wire logic shift_in,
   input wire logic serial_in_bit_in,
   input wire logic busy_in,
   output logic [7:0] sreg_out,
   output logic serial_out
);
   typedef struct packed {
      logic [7:0] sreg;
      logic [3:0] count;
      logic parity;
   } fhb_shift_state_t;

   fhb_shift_state_t st_reg;
   fhb_shift_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!busy_in) begin
         st_next.count = SER_CNT_RST;
      end
      if (load_in && !busy_in) begin
         st_next.sreg = load_data_in;
         st_next.parity = (^load_data_in) ^ ODD_PARITY;
      end else if (shift_in && busy_in && !load_in) begin
         st_next.sreg = {st_reg.sreg[6:0], serial_in_bit_in};
         if (st_reg.count <= 4'(SER_BITS)) begin
            st_next.count = st_reg.count + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_reg <= '{sreg: SREG_RST, count: SER_CNT_RST, parity: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sreg_out = st_reg.sreg;
   // Ninth bit on the wire is the parity bit
   assign serial_out = (st_reg.count == 4'(SER_BITS)) ? st_reg.parity : st_reg.sreg[7];

   a_parity_slot: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (st_reg.count == 4'(SER_BITS)) |-> (serial_out == st_reg.parity))
      else $error("parity bit not presented after eight data bits");
endmodule

// file: hdl/fhb_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module fhb_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } fhb_sync_state_t;

   fhb_sync_state_t st_reg;
   fhb_sync_state_t st_next;

   always_comb begin
      st_next.meta = async_in;
      st_next.stable = st_reg.meta;
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.stable;
endmodule

// file: verif/fhb_ctl_model.sv
// Behavioural model of the disk controller end of the serial link
`timescale 1ns/100ps
module fhb_ctl_model (
   input wire logic sys_clk_in,
   input wire logic serial_out_bit_in,
   output logic xfer_request_out,
   output logic link_done_out,
   output logic link_out_dir_out,
   output logic link_error_out,
   output logic serial_shift_pulse_out,
   output logic serial_in_bit_out
);
   initial begin
      xfer_request_out = 1'b0;
      link_done_out = 1'b1;
      link_out_dir_out = 1'b0;
      link_error_out = 1'b0;
      serial_shift_pulse_out = 1'b0;
      serial_in_bit_out = 1'b0;
   end
   // Levels change just after a system edge
   task automatic set_lines(input logic req, input logic done, input logic dir,
      input logic err);
      @(posedge sys_clk_in);
      xfer_request_out <= req;
      link_done_out <= done;
      link_out_dir_out <= dir;
      link_error_out <= err;
   endtask
   // Shift clock runs only inside a frame: six system cycles high, six low (48 ns)
   task automatic frame(input logic [7:0] tx, input int n, output logic [8:0] rx);
      rx = 9'h000;
      @(posedge sys_clk_in);
      for (int i = 0; i < n; i++) begin
         serial_in_bit_out <= (i < 8) ? tx[7 - i] : 1'b0;
         repeat (6) @(posedge sys_clk_in);
         rx = {rx[7:0], serial_out_bit_in};
         serial_shift_pulse_out <= 1'b1;
         repeat (6) @(posedge sys_clk_in);
         serial_shift_pulse_out <= 1'b0;
      end
      // Released line must not keep showing the last bit
      serial_in_bit_out <= ~serial_in_bit_out;
   endtask
endmodule

// file: verif/floppy_host_bus_interface_tb.sv
// Self-checking bench for the floppy host bus interface
`timescale 1ns/100ps
module floppy_host_bus_interface_tb;
   import fhb_pkg::*;
   localparam logic [17:0] CSR_A = {ADDR_TOP_ONES, ADDR_JMP_DEF, 3'b000};
   localparam logic [17:0] DB_A = CSR_A | 18'h00002;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [17:0] addr = 18'h00000;
   logic msyn = 1'b0;
   logic c1 = 1'b0;
   logic init = 1'b0;
   logic ssyn_in = 1'b0;
   logic grant = 1'b0;
   logic bbsy_in = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] dout, doe, rd, roe;
   logic ssyn, req, bbsy, intr, xreq, done, dir, err, pulse, sin, sout, run, init_out, ok;
   logic [8:0] rx;
   int fail_count = 0;
   int compares = 0;
   always #2 sys_clk_in = ~sys_clk_in;
   fhb_bus_iface fhb_bus_iface_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .bus_addr_in(addr), .bus_msyn_in(msyn), .bus_c1_in(c1), .bus_init_in(init),
      .bus_data_in(wdata), .bus_data_out(dout), .bus_data_oe_out(doe),
      .bus_ssyn_out(ssyn), .bus_ssyn_in(ssyn_in), .bus_request_out(req),
      .grant_input_in(grant), .bus_bbsy_in(bbsy_in), .bus_bbsy_out(bbsy),
      .bus_intr_out(intr), .xfer_request_in(xreq), .link_done_in(done),
      .link_out_dir_in(dir), .link_error_in(err), .serial_shift_pulse_in(pulse),
      .serial_in_bit_in(sin), .serial_out_bit_out(sout), .link_run_out(run),
      .interface_initialize_out(init_out));
   fhb_ctl_model fhb_ctl_model_inst (.sys_clk_in(sys_clk_in), .serial_out_bit_in(sout),
      .xfer_request_out(xreq), .link_done_out(done), .link_out_dir_out(dir),
      .link_error_out(err), .serial_shift_pulse_out(pulse), .serial_in_bit_out(sin));
   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   localparam int P_SSYN = 0;
   localparam int P_RUN = 1;
   localparam int P_INIT = 2;
   localparam int P_REQ = 3;
   localparam int P_BBSY = 4;
   // Watched output picked by number, so the wait loop needs no ref argument
   function automatic logic probe(input int sel);
      case (sel)
         P_SSYN: probe = ssyn;
         P_RUN: probe = run;
         P_INIT: probe = init_out;
         P_REQ: probe = req;
         default: probe = bbsy;
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic v, input string name);
      int n = 0;
      while (probe(sel) !== v && n < 40) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      chk(name, {15'h0000, v}, {15'h0000, probe(sel)});
      if (probe(sel) !== v) begin
         give_verdict();
      end
   endtask
   // Address settles an edge before master sync; request held until the reply
   task automatic bus_cycle(input logic [17:0] a, input logic wr, input logic [15:0] d,
      input logic ack);
      int n = 0;
      @(posedge sys_clk_in);
      addr <= a;
      c1 <= wr;
      wdata <= d;
      @(posedge sys_clk_in);
      msyn <= 1'b1;
      ok = 1'b0;
      while (!ok && n < 20) begin
         @(posedge sys_clk_in);
         #1;
         ok = (ssyn === 1'b1);
         n++;
      end
      rd = dout;
      roe = doe;
      chk("ssyn reply", {15'h0000, ack}, {15'h0000, ok});
      @(posedge sys_clk_in);
      msyn <= 1'b0;
      if (ok) begin
         wait_for(P_SSYN, 1'b0, "ssyn drop");
      end
      if (ok !== ack) begin
         give_verdict();
      end
   endtask
   task automatic settle();
      repeat (4) @(posedge sys_clk_in);
   endtask
   task automatic t_status();
      fhb_ctl_model_inst.set_lines(1'b1, 1'b1, 1'b0, 1'b1);
      settle();
      bus_cycle(CSR_A, 1'b0, 16'h0000, 1'b1);
      chk("ack", 16'h0001, {15'h0000, ok});
      chk("csr oe", 16'h80f0, roe);
      chk("csr", 16'h80a0, rd & roe);
      chk("no req ie off", 16'h0000, {15'h0000, req});
      fhb_ctl_model_inst.set_lines(1'b1, 1'b1, 1'b0, 1'b0);
      settle();
      bus_cycle(CSR_A, 1'b0, 16'h0000, 1'b1);
      chk("csr oe no err", 16'h00f0, roe);
   endtask
   task automatic t_bad_addr();
      bus_cycle(CSR_A ^ 18'h00008, 1'b0, 16'h0000, 1'b0);
      chk("jumper miss", 16'h0000, {15'h0000, ok});
      bus_cycle(CSR_A ^ 18'h20000, 1'b0, 16'h0000, 1'b0);
      chk("top miss", 16'h0000, {15'h0000, ok});
   endtask
   task automatic t_send();
      fhb_ctl_model_inst.set_lines(1'b0, 1'b1, 1'b0, 1'b0);
      settle();
      bus_cycle(DB_A, 1'b1, 16'h00a5, 1'b1);
      chk("write oe", 16'h0000, roe);
      chk("run", 16'h0001, {15'h0000, run});
      fhb_ctl_model_inst.set_lines(1'b0, 1'b0, 1'b0, 1'b0);
      wait_for(P_RUN, 1'b0, "run busy clear");
      fhb_ctl_model_inst.frame(8'h00, 9, rx);
      chk("tx", {7'h00, 8'ha5, (^8'ha5) ^ 1'b1}, {7'h00, rx});
      fhb_ctl_model_inst.set_lines(1'b1, 1'b0, 1'b1, 1'b0);
      settle();
   endtask
   task automatic t_recv();
      bus_cycle(DB_A, 1'b0, 16'h0000, 1'b1);
      chk("run rd", 16'h0001, {15'h0000, run});
      fhb_ctl_model_inst.set_lines(1'b0, 1'b0, 1'b1, 1'b0);
      wait_for(P_RUN, 1'b0, "run busy clear 2");
      fhb_ctl_model_inst.frame(8'h3c, 8, rx);
      fhb_ctl_model_inst.set_lines(1'b1, 1'b0, 1'b1, 1'b0);
      settle();
      bus_cycle(DB_A, 1'b0, 16'h0000, 1'b1);
      chk("db oe", 16'h00ff, roe);
      chk("db", 16'h003c, rd & roe);
   endtask
   task automatic t_init();
      @(posedge sys_clk_in);
      init <= 1'b1;
      wait_for(P_RUN, 1'b0, "run init clear");
      wait_for(P_INIT, 1'b1, "init out");
      @(posedge sys_clk_in);
      init <= 1'b0;
      wait_for(P_INIT, 1'b0, "init out drop");
   endtask
   task automatic t_irq();
      fhb_ctl_model_inst.set_lines(1'b0, 1'b1, 1'b0, 1'b0);
      bus_cycle(CSR_A, 1'b1, 16'h0040, 1'b1);
      bus_cycle(CSR_A, 1'b0, 16'h0000, 1'b1);
      chk("csr ie", 16'h0060, rd & roe);
      wait_for(P_REQ, 1'b1, "request");
      @(posedge sys_clk_in);
      grant <= 1'b1;
      bbsy_in <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      #1;
      chk("early master", 16'h0000, {15'h0000, bbsy});
      @(posedge sys_clk_in);
      grant <= 1'b0;
      bbsy_in <= 1'b0;
      wait_for(P_BBSY, 1'b1, "master");
      chk("intr", 16'h0001, {15'h0000, intr});
      chk("req off", 16'h0000, {15'h0000, req});
      chk("vec oe", 16'h01fc, doe & 16'h01fc);
      chk("vec", {7'h00, VECTOR_DEF[8:2], 2'b00}, dout & 16'h01fc);
      @(posedge sys_clk_in);
      ssyn_in <= 1'b1;
      wait_for(P_BBSY, 1'b0, "master end");
      @(posedge sys_clk_in);
      ssyn_in <= 1'b0;
      // Serviced once; no second request while done and enable stay up
      repeat (6) @(posedge sys_clk_in);
      #1;
      chk("no re-request", 16'h0000, {15'h0000, req});
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk("reset run", 16'h0000, {15'h0000, run});
      chk("reset oe", 16'h0000, doe);
      t_status();
      t_bad_addr();
      t_send();
      t_recv();
      t_init();
      t_irq();
      give_verdict();
   end
endmodule
